// file: design/gcf_pkg.sv
package gcf_pkg;

	// timing
	localparam int unsigned CLK_PERIOD_NS  = 8;
	localparam int unsigned TICK_PERIOD_NS = 1000000;
	localparam int unsigned TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// angles: cam angle in millidegrees, virtual angle in microdegrees
	localparam int unsigned       TABLE_POINTS   = 3600;
	localparam logic signed [31:0] FULL_TURN_MDEG = 32'sh0005_7e40;
	localparam logic signed [31:0] FULL_TURN_UDEG = 32'sh1575_2a00;
	localparam logic signed [31:0] HALF_TURN_MDEG = 32'sh0002_bf20;
	localparam logic signed [31:0] MDEG_PER_POINT = 32'sh0000_0064;
	localparam logic signed [31:0] UDEG_PER_MDEG  = 32'sh0000_03e8;

	// amplitude scale in hundredths: 0.01 .. 100, reset 1.00
	localparam logic signed [31:0] SCALE_UNITY = 32'sh0000_0064;
	localparam logic signed [31:0] SCALE_MIN   = 32'sh0000_0001;
	localparam logic signed [31:0] SCALE_MAX   = 32'sh0000_2710;

	localparam logic [2:0] SMOOTH_MAX = 3'h4;

	// register offsets
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_HALF_LEN  = 8'h04;
	localparam logic [7:0] REG_AUX_OFS   = 8'h08;
	localparam logic [7:0] REG_AUX_CNT   = 8'h0c;
	localparam logic [7:0] REG_VANGLE    = 8'h10;
	localparam logic [7:0] REG_VRATE     = 8'h14;
	localparam logic [7:0] REG_SMOOTH    = 8'h18;
	localparam logic [7:0] REG_PHASE     = 8'h1c;
	localparam logic [7:0] REG_SCALE     = 8'h20;
	localparam logic [7:0] REG_TIDX      = 8'h24;
	localparam logic [7:0] REG_TDATA     = 8'h28;
	localparam logic [7:0] REG_CAM_ANGLE = 8'h2c;
	localparam logic [7:0] REG_ACCEL     = 8'h30;
	localparam logic [7:0] REG_VEL       = 8'h34;

	// control register fields
	localparam int unsigned CTRL_GEAR_BIT = 0;
	localparam int unsigned CTRL_CAM_BIT  = 1;
	localparam int unsigned CTRL_SEL_BIT  = 2;
	localparam int unsigned CTRL_CLR_BIT  = 3;
	localparam int unsigned CTRL_KIND_LSB = 4;
	localparam int unsigned CTRL_BUSY_BIT = 8;
	localparam int unsigned CTRL_LOCK_BIT = 9;

	localparam logic signed [31:0] RESET_HALF_LEN = 32'sh0000_03e8;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        we;
		logic        re;
	} gcf_bus_s;

	typedef enum logic [2:0] {
		CAM_OFF   = 3'b001,
		CAM_ALIGN = 3'b010,
		CAM_LOCK  = 3'b100
	} gcf_cam_e;

endpackage : gcf_pkg

// file: design/gcf_top.sv
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ns
// How it works
// - gearing enable written from registers or blocks
// - fault clears gearing enable at once
// - gearing output summed onto motion command
// - cam output wraps cyclically while enabled
// - table holds 3600 points, tenth-degree spacing
// - master select picks aux or virtual
// - write-only offset added to aux count
// - aux count bounded by plus/minus length
// - past plus length jumps to minus length
// - cam angle wraps where count crosses zero
// - virtual angle wraps at both ends
// - virtual angle moves by signed rate
// - virtual angle runs only while enabled
// - angle and rate writable any time
// - moving average with selectable depth
// - phase shift added for lookup only
// - phase change corrected at full speed
// - clear command erases every table point
// - axis commanded to point of angle
// - enable aligns axis under move limits
// - table values multiplied by amplitude scale
module gcf_top #(
	parameter int unsigned TICK_CYCLES = gcf_pkg::TICK_CYCLES
) (
	input  wire logic                clk_i,          // system clock
	input  wire logic                reset_i,        // sync reset, high
	input  wire gcf_pkg::gcf_bus_s   bus_i,          // register strobes
	output logic        [31:0]       rd_data_o,      // read data
	input  wire logic                aux_step_i,     // one master count
	input  wire logic                aux_dir_i,      // 1 = count down
	input  wire logic                fault_i,        // any fault
	input  wire logic                gear_req_i,     // motion block gear write
	input  wire logic                gear_req_val_i, // value of that write
	input  wire logic signed [31:0]  gear_out_i,     // gearing output
	input  wire logic signed [31:0]  motion_cmd_i,   // motion generator command
	output logic signed [31:0]       pos_cmd_o,      // axis position command
	output logic                     gear_active_o,  // gearing on
	output logic                     cam_locked_o,   // cam tracking table
	output logic                     table_busy_o    // clear in progress
);
	localparam int unsigned HIST_DEPTH = 1 << gcf_pkg::SMOOTH_MAX;
	localparam logic signed [31:0] UDEG_TICKS = 32'sh0000_03e8;

	typedef struct packed {
		logic                          gear_en;
		logic                          cam_en;
		logic                          cam_sel;
		logic [2:0]                    kind;
		logic [2:0]                    smooth;
		logic signed [31:0]            half_len;
		logic signed [31:0]            aux_cnt;
		logic signed [31:0]            vangle;
		logic signed [31:0]            vrate;
		logic signed [31:0]            phase;
		logic signed [31:0]            scale;
		logic signed [31:0]            accel;
		logic signed [31:0]            vel_lim;
		logic signed [31:0]            vel;
		logic signed [31:0]            cam_angle;
		logic signed [31:0]            cam_out;
		logic signed [31:0]            target;
		logic signed [31:0]            pos_cmd;
		logic [HIST_DEPTH-1:0][31:0]   hist;
		logic [11:0]                   wr_idx;
		logic [11:0]                   clr_idx;
		logic                          busy;
		logic                          locked;
		logic [31:0]                   tick_cnt;
		logic [31:0]                   rd_data;
		gcf_pkg::gcf_cam_e             cam_st;
	} gcf_state_s;

	gcf_state_s         q;
	gcf_state_s         d;
	logic signed [31:0] table_q [gcf_pkg::TABLE_POINTS];
	logic signed [31:0] lut_q;
	logic [11:0]        rd_idx;
	logic               tbl_we;

	function automatic logic signed [31:0] wrapmod(input logic signed [31:0] v,
		input logic signed [31:0] m);
		if (v < 0)
			wrapmod = v + m;
		else if (v >= m)
			wrapmod = v - m;
		else
			wrapmod = v;
	endfunction : wrapmod

	function automatic logic signed [31:0] aux_angle(input logic signed [31:0] c,
		input logic signed [31:0] len);
		logic signed [31:0] span;
		logic [63:0]        prod;
		span = (len <<< 1) + 32'sh0000_0001;
		prod = 64'($unsigned(c < 0 ? c + span : c)) * 64'($unsigned(gcf_pkg::FULL_TURN_MDEG));
		if (len <= 0)
			aux_angle = 32'sh0000_0000;
		else
			aux_angle = $signed(32'(prod / 64'($unsigned(span))));
	endfunction : aux_angle

	always_comb begin
		logic               tick;
		logic signed [31:0] span;
		logic signed [31:0] ofs;
		logic signed [31:0] cnt;
		logic signed [63:0] prod;
		logic signed [39:0] acc;
		logic signed [31:0] scaled;
		logic signed [31:0] diff;
		logic signed [31:0] step;
		d      = q;
		tick   = (q.tick_cnt == TICK_CYCLES - 1);
		span   = (q.half_len <<< 1) + 32'sh0000_0001;
		ofs    = 32'sh0000_0000;
		acc    = 40'sh00_0000_0000;
		diff   = 32'sh0000_0000;
		step   = 32'sh0000_0000;
		cnt    = 32'sh0000_0000;
		prod   = 64'sh0000_0000_0000_0000;
		scaled = 32'sh0000_0000;
		tbl_we = 1'b0;
		d.tick_cnt = tick ? 32'h0000_0000 : q.tick_cnt + 32'h0000_0001;
		d.rd_data  = 32'h0000_0000;

		// one point erased per cycle; a new clear below wins
		if (q.busy) begin
			d.clr_idx = q.clr_idx + 12'h001;
			if (q.clr_idx == 12'(gcf_pkg::TABLE_POINTS - 1))
				d.busy = 1'b0;
		end

		if (bus_i.we) begin
			if (bus_i.addr == gcf_pkg::REG_CTRL) begin
				d.gear_en = bus_i.wdata[gcf_pkg::CTRL_GEAR_BIT];
				d.cam_en  = bus_i.wdata[gcf_pkg::CTRL_CAM_BIT];
				d.cam_sel = bus_i.wdata[gcf_pkg::CTRL_SEL_BIT];
				d.kind    = bus_i.wdata[gcf_pkg::CTRL_KIND_LSB +: 3];
				if (bus_i.wdata[gcf_pkg::CTRL_CLR_BIT]) begin
					d.busy    = 1'b1;
					d.clr_idx = 12'h000;
				end
			end else if (bus_i.addr == gcf_pkg::REG_HALF_LEN) begin
				d.half_len = $signed(bus_i.wdata);
			end else if (bus_i.addr == gcf_pkg::REG_AUX_OFS) begin
				ofs = $signed(bus_i.wdata);
			end else if (bus_i.addr == gcf_pkg::REG_SMOOTH) begin
				d.smooth = (bus_i.wdata > 32'(gcf_pkg::SMOOTH_MAX)) ? gcf_pkg::SMOOTH_MAX
					: bus_i.wdata[2:0];
			end else if (bus_i.addr == gcf_pkg::REG_PHASE) begin
				d.phase = $signed(bus_i.wdata);
				if (d.phase > gcf_pkg::HALF_TURN_MDEG)
					d.phase = gcf_pkg::HALF_TURN_MDEG;
				if (d.phase < -gcf_pkg::HALF_TURN_MDEG)
					d.phase = -gcf_pkg::HALF_TURN_MDEG;
			end else if (bus_i.addr == gcf_pkg::REG_SCALE) begin
				d.scale = $signed(bus_i.wdata);
				if (d.scale < gcf_pkg::SCALE_MIN)
					d.scale = gcf_pkg::SCALE_MIN;
				if (d.scale > gcf_pkg::SCALE_MAX)
					d.scale = gcf_pkg::SCALE_MAX;
			end else if (bus_i.addr == gcf_pkg::REG_TIDX) begin
				d.wr_idx = bus_i.wdata[11:0];
			end else if (bus_i.addr == gcf_pkg::REG_TDATA) begin
				// loads are dropped while a clear sweeps the table
				if (!q.busy && q.wr_idx < 12'(gcf_pkg::TABLE_POINTS)) begin
					tbl_we   = 1'b1;
					d.wr_idx = (q.wr_idx == 12'(gcf_pkg::TABLE_POINTS - 1)) ? 12'h000
						: q.wr_idx + 12'h001;
				end
			end else if (bus_i.addr == gcf_pkg::REG_ACCEL) begin
				d.accel = $signed(bus_i.wdata);
			end else if (bus_i.addr == gcf_pkg::REG_VEL) begin
				d.vel_lim = $signed(bus_i.wdata);
			end
		end

		if (gear_req_i)
			d.gear_en = gear_req_val_i;
		if (fault_i)
			d.gear_en = 1'b0;

		cnt = q.aux_cnt + ofs;
		if (aux_step_i)
			cnt = aux_dir_i ? cnt - 32'sh0000_0001 : cnt + 32'sh0000_0001;
		// one fold keeps count in range
		// plus length plus one lands on minus length
		if (cnt > q.half_len)
			cnt = cnt - span;
		else if (cnt < -q.half_len)
			cnt = cnt + span;
		d.aux_cnt = cnt;

		// virtual angle moves only while enabled
		if (q.cam_en && tick)
			d.vangle = wrapmod(q.vangle + q.vrate / $signed(UDEG_TICKS), gcf_pkg::FULL_TURN_UDEG);
		if (bus_i.we && bus_i.addr == gcf_pkg::REG_VANGLE)
			d.vangle = wrapmod($signed(bus_i.wdata), gcf_pkg::FULL_TURN_UDEG);
		if (bus_i.we && bus_i.addr == gcf_pkg::REG_VRATE)
			d.vrate = $signed(bus_i.wdata);

		// aux angle is zero where count is zero
		d.cam_angle = q.cam_sel ? q.vangle / gcf_pkg::UDEG_PER_MDEG
			: aux_angle(q.aux_cnt, q.half_len);

		prod   = 64'(lut_q) * 64'(q.scale);
		scaled = 32'(prod / 64'(gcf_pkg::SCALE_UNITY));
		// history sampled each tick, averaged over 2^depth
		if (tick)
			d.hist = {q.hist[HIST_DEPTH-2:0], scaled};
		for (int i = 0; i < HIST_DEPTH; i++) begin
			if (i < (1 << q.smooth))
				acc = acc + 40'($signed(q.hist[i]));
		end
		d.target = (q.smooth == 3'h0) ? scaled : 32'(acc >>> q.smooth);

		d.vel = q.vel;
		case (q.cam_st)
			gcf_pkg::CAM_OFF: begin
				if (q.cam_en) begin
					d.cam_st = gcf_pkg::CAM_ALIGN;
					d.vel    = 32'sh0000_0000;
				end
			end
			gcf_pkg::CAM_ALIGN: begin
				// approach start point under accel and velocity limits
				if (!q.cam_en) begin
					d.cam_st = gcf_pkg::CAM_OFF;
				end else if (tick) begin
					step = q.vel + q.accel;
					if (step > q.vel_lim)
						step = q.vel_lim;
					d.vel = step;
					diff  = q.target - q.cam_out;
					if (diff <= step && diff >= -step) begin
						d.cam_out = q.target;
						d.cam_st  = gcf_pkg::CAM_LOCK;
					end else begin
						d.cam_out = (diff > 0) ? q.cam_out + step : q.cam_out - step;
					end
				end
			end
			gcf_pkg::CAM_LOCK: begin
				// no limits once locked, phase steps land at once
				// table wraps with angle, profile repeats
				d.cam_out = q.target;
				if (!q.cam_en)
					d.cam_st = gcf_pkg::CAM_OFF;
			end
			default: d.cam_st = gcf_pkg::CAM_OFF;
		endcase

		d.locked = (d.cam_st == gcf_pkg::CAM_LOCK);

		// gearing superimposed on any motion kind
		d.pos_cmd = motion_cmd_i + (q.gear_en ? gear_out_i : 32'sh0000_0000) + q.cam_out;

		if (bus_i.re) begin
			if (bus_i.addr == gcf_pkg::REG_CTRL) begin
				d.rd_data[gcf_pkg::CTRL_GEAR_BIT]     = q.gear_en;
				d.rd_data[gcf_pkg::CTRL_CAM_BIT]      = q.cam_en;
				d.rd_data[gcf_pkg::CTRL_SEL_BIT]      = q.cam_sel;
				d.rd_data[gcf_pkg::CTRL_KIND_LSB +: 3] = q.kind;
				d.rd_data[gcf_pkg::CTRL_BUSY_BIT]     = q.busy;
				d.rd_data[gcf_pkg::CTRL_LOCK_BIT]     = (q.cam_st == gcf_pkg::CAM_LOCK);
			end else if (bus_i.addr == gcf_pkg::REG_HALF_LEN) begin
				d.rd_data = q.half_len;
			end else if (bus_i.addr == gcf_pkg::REG_AUX_CNT) begin
				d.rd_data = q.aux_cnt;
			end else if (bus_i.addr == gcf_pkg::REG_VANGLE) begin
				d.rd_data = q.vangle;
			end else if (bus_i.addr == gcf_pkg::REG_VRATE) begin
				d.rd_data = q.vrate;
			end else if (bus_i.addr == gcf_pkg::REG_SMOOTH) begin
				d.rd_data = {29'h0000_0000, q.smooth};
			end else if (bus_i.addr == gcf_pkg::REG_PHASE) begin
				d.rd_data = q.phase;
			end else if (bus_i.addr == gcf_pkg::REG_SCALE) begin
				d.rd_data = q.scale;
			end else if (bus_i.addr == gcf_pkg::REG_TIDX) begin
				d.rd_data = {20'h0_0000, q.wr_idx};
			end else if (bus_i.addr == gcf_pkg::REG_CAM_ANGLE) begin
				d.rd_data = q.cam_angle;
			end else if (bus_i.addr == gcf_pkg::REG_ACCEL) begin
				d.rd_data = q.accel;
			end else if (bus_i.addr == gcf_pkg::REG_VEL) begin
				d.rd_data = q.vel_lim;
			end
		end
	end

	// phase added to a copy, stored angle untouched
	// index is offset angle over one tenth degree
	always_comb begin
		logic signed [31:0] la;
		la     = wrapmod(q.cam_angle + q.phase, gcf_pkg::FULL_TURN_MDEG);
		rd_idx = 12'(la / gcf_pkg::MDEG_PER_POINT);
	end

	// one absolute position per tenth degree
	// equal end points keep the wrap seamless
	always_ff @(posedge clk_i) begin
		if (q.busy)
			table_q[q.clr_idx] <= 32'sh0000_0000;
		else if (tbl_we)
			table_q[q.wr_idx] <= $signed(bus_i.wdata);
		lut_q <= table_q[rd_idx];
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			q          <= '0;
			q.scale    <= gcf_pkg::SCALE_UNITY;
			q.half_len <= gcf_pkg::RESET_HALF_LEN;
			q.cam_st   <= gcf_pkg::CAM_OFF;
		end else begin
			q <= d;
		end
	end

	assign rd_data_o     = q.rd_data;
	assign pos_cmd_o     = q.pos_cmd;
	assign gear_active_o = q.gear_en;
	assign cam_locked_o  = q.locked;
	assign table_busy_o  = q.busy;

	a_fault_gear_off: assert property (@(posedge clk_i) disable iff (reset_i)
		fault_i |=> !gear_active_o ##1 (!gear_active_o || $past(gear_req_i) || $past(bus_i.we)))
		else $error("gearing stayed on after fault");
	a_gear_sum_out: assert property (@(posedge clk_i) disable iff (reset_i)
		!$past(reset_i) |-> pos_cmd_o == $past(motion_cmd_i)
			+ ($past(q.gear_en) ? $past(gear_out_i) : 32'sh0) + $past(q.cam_out))
		else $error("position command is not the sum");
	a_aux_wrap_up: assert property (@(posedge clk_i) disable iff (reset_i)
		(q.aux_cnt == q.half_len && aux_step_i && !aux_dir_i && !bus_i.we)
			|=> q.aux_cnt == -q.half_len)
		else $error("aux count did not jump to minus length");
	a_aux_bounded: assert property (@(posedge clk_i) disable iff (reset_i)
		(!bus_i.we && q.aux_cnt <= q.half_len && q.aux_cnt >= -q.half_len)
			|=> (q.aux_cnt <= q.half_len && q.aux_cnt >= -q.half_len))
		else $error("aux count left its bounds");
	a_vangle_frozen: assert property (@(posedge clk_i) disable iff (reset_i)
		(!q.cam_en && !bus_i.we) |=> $stable(q.vangle))
		else $error("virtual angle moved while disabled");
	a_vangle_range: assert property (@(posedge clk_i) disable iff (reset_i)
		q.vangle >= 0 && q.vangle < gcf_pkg::FULL_TURN_UDEG)
		else $error("virtual angle out of range");
	a_index_range: assert property (@(posedge clk_i) disable iff (reset_i)
		rd_idx < 12'(gcf_pkg::TABLE_POINTS))
		else $error("table index out of range");
	a_clear_sweep: assert property (@(posedge clk_i) disable iff (reset_i)
		(q.busy && q.clr_idx != 12'(gcf_pkg::TABLE_POINTS - 1) && !bus_i.we)
			|=> q.busy && q.clr_idx == $past(q.clr_idx) + 12'h001)
		else $error("clear sweep stalled");
	a_lock_track: assert property (@(posedge clk_i) disable iff (reset_i)
		(q.cam_st == gcf_pkg::CAM_LOCK && q.cam_en) |=> q.cam_out == $past(q.target))
		else $error("locked cam output not on target");
	a_master_default: assert property (@(posedge clk_i)
		$fell(reset_i) |-> !q.cam_sel ##1 (!q.cam_sel || $past(bus_i.we)))
		else $error("master select not aux after reset");
endmodule : gcf_top

// file: verif/gcf_aux_master.sv
`timescale 1ns/1ns
module gcf_aux_master (
	input  wire logic clk_i,  // system clock
	output logic      step_o, // one master count
	output logic      dir_o   // 1 = count down
);
	logic busy_q;

	initial begin
		step_o = 1'b0;
		dir_o  = 1'b0;
		busy_q = 1'b0;
	end

	// direction means nothing without a pulse, so keep it moving
	always @(posedge clk_i) begin
		if (!busy_q) begin
			dir_o <= ~dir_o;
		end
	end

	// one pulse every second cycle, as a slow encoder would
	task automatic steps(input int n, input logic down);
		busy_q = 1'b1;
		repeat (n) begin
			@(posedge clk_i);
			step_o <= 1'b1;
			dir_o  <= down;
			@(posedge clk_i);
			step_o <= 1'b0;
		end
		busy_q = 1'b0;
	endtask : steps
endmodule : gcf_aux_master

// file: verif/gcf_top_test.sv
`timescale 1ns/1ns
module gcf_top_test;
	logic                clk_i;
	logic                reset_i;
	gcf_pkg::gcf_bus_s   bus_i;
	logic        [31:0]  rd_data_o;
	logic        [31:0]  v;
	logic                aux_step;
	logic                aux_dir;
	logic                fault_i;
	logic                gear_req_i;
	logic                gear_req_val_i;
	logic signed [31:0]  gear_out_i;
	logic signed [31:0]  motion_cmd_i;
	logic signed [31:0]  pos_cmd_o;
	logic                gear_active_o;
	logic                cam_locked_o;
	logic                table_busy_o;
	int                  n_mismatch;
	int                  n_checks;
	int                  k;

	gcf_top #(.TICK_CYCLES(8)) gcf_top_i (
		.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_i), .rd_data_o(rd_data_o),
		.aux_step_i(aux_step), .aux_dir_i(aux_dir), .fault_i(fault_i),
		.gear_req_i(gear_req_i), .gear_req_val_i(gear_req_val_i),
		.gear_out_i(gear_out_i), .motion_cmd_i(motion_cmd_i), .pos_cmd_o(pos_cmd_o),
		.gear_active_o(gear_active_o), .cam_locked_o(cam_locked_o),
		.table_busy_o(table_busy_o)
	);

	gcf_aux_master gcf_aux_master_i (.clk_i(clk_i), .step_o(aux_step), .dir_o(aux_dir));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		bus_i <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
		@(posedge clk_i);
		bus_i.we <= 1'b0;
	endtask : wr

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		bus_i <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
		@(posedge clk_i);
		bus_i.re <= 1'b0;
		#1 v = rd_data_o;
	endtask : rd

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
		rd(a);
		chk(n, e, v);
	endtask : rchk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : cyc

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : print_verdict

	initial begin
		// several times the expected run, clear sweep included
		#200000;
		n_mismatch++;
		print_verdict();
	end

	initial begin
		reset_i = 1'b1;
		bus_i = '0;
		fault_i = 1'b0;
		gear_req_i = 1'b0;
		gear_req_val_i = 1'b0;
		gear_out_i = 32'sh7;
		motion_cmd_i = 32'sh64;
		n_mismatch = 0;
		n_checks = 0;
		repeat (5) @(posedge clk_i);
		reset_i <= 1'b0;
		rchk(gcf_pkg::REG_CTRL, 32'h0, "ctrl_rst");
		rchk(gcf_pkg::REG_HALF_LEN, 32'h3e8, "len_rst");
		rchk(gcf_pkg::REG_SCALE, 32'h64, "scale_rst");
		cyc(1);
		chk("rd_idle", 32'h0, rd_data_o);
		rchk(8'hfc, 32'h0, "unmapped");
		$display("test reset done");

		wr(gcf_pkg::REG_CTRL, 32'h1);
		cyc(3);
		chk("gear_on", 32'h1, 32'(gear_active_o));
		chk("pos_gear", 32'h6b, pos_cmd_o);
		@(posedge clk_i) fault_i <= 1'b1;
		@(posedge clk_i) fault_i <= 1'b0;
		cyc(2);
		chk("gear_fault", 32'h0, 32'(gear_active_o));
		chk("pos_fault", 32'h64, pos_cmd_o);
		@(posedge clk_i);
		gear_req_i <= 1'b1;
		gear_req_val_i <= 1'b1;
		@(posedge clk_i) gear_req_i <= 1'b0;
		cyc(2);
		chk("gear_block", 32'h1, 32'(gear_active_o));
		for (k = 0; k < 8; k++) begin
			wr(gcf_pkg::REG_CTRL, 32'(k << 4) | 32'h1);
			cyc(2);
			chk("gear_kind", 32'h6b, pos_cmd_o);
		end
		wr(gcf_pkg::REG_CTRL, 32'h0);
		$display("test gearing done");

		wr(gcf_pkg::REG_HALF_LEN, 32'h3);
		gcf_aux_master_i.steps(3, 1'b0);
		rchk(gcf_pkg::REG_AUX_CNT, 32'h3, "cnt_top");
		rchk(gcf_pkg::REG_CAM_ANGLE, 32'h25aad, "ang_top");
		gcf_aux_master_i.steps(1, 1'b0);
		rchk(gcf_pkg::REG_AUX_CNT, 32'hffff_fffd, "cnt_wrap");
		gcf_aux_master_i.steps(3, 1'b0);
		rchk(gcf_pkg::REG_CAM_ANGLE, 32'h0, "ang_zero");
		wr(gcf_pkg::REG_AUX_OFS, 32'hffff_fffe);
		rchk(gcf_pkg::REG_AUX_CNT, 32'hffff_fffe, "cnt_ofs");
		rchk(gcf_pkg::REG_AUX_OFS, 32'h0, "ofs_wo");
		$display("test aux done");

		// clear sweep keeps busy one cycle per point, 3600 cycles in all
		wr(gcf_pkg::REG_CTRL, 32'h8);
		k = 0;
		while (table_busy_o !== 1'b1 && k < 10) begin
			cyc(1);
			k++;
		end
		// first busy cycle was already seen by the wait above
		k = 1;
		while (table_busy_o === 1'b1 && k < 5000) begin
			cyc(1);
			k++;
		end
		chk("clear_len", 32'd3600, 32'(k));
		$display("test clear done");

		wr(gcf_pkg::REG_CTRL, 32'h4);
		wr(gcf_pkg::REG_VRATE, 32'h0);
		wr(gcf_pkg::REG_VANGLE, 32'h055d_4a80);
		wr(gcf_pkg::REG_TIDX, 32'h384);
		wr(gcf_pkg::REG_TDATA, 32'h1f4);
		wr(gcf_pkg::REG_SCALE, 32'hc8);
		wr(gcf_pkg::REG_ACCEL, 32'h0010_0000);
		wr(gcf_pkg::REG_VEL, 32'h0010_0000);
		wr(gcf_pkg::REG_CTRL, 32'h6);
		k = 0;
		while (cam_locked_o !== 1'b1 && k < 2000) begin
			cyc(1);
			k++;
		end
		cyc(4);
		chk("cam_lock", 32'h1, 32'(cam_locked_o));
		chk("pos_cam", 32'h44c, pos_cmd_o);
		rchk(gcf_pkg::REG_CAM_ANGLE, 32'h15f90, "ang_virt");
		wr(gcf_pkg::REG_PHASE, 32'h64);
		cyc(6);
		chk("pos_phase", 32'h64, pos_cmd_o);
		rchk(gcf_pkg::REG_CAM_ANGLE, 32'h15f90, "ang_keep");
		wr(gcf_pkg::REG_PHASE, 32'h0010_0000);
		rchk(gcf_pkg::REG_PHASE, 32'h0002_bf20, "phase_max");
		wr(gcf_pkg::REG_SCALE, 32'h0);
		rchk(gcf_pkg::REG_SCALE, 32'h1, "scale_min");
		wr(gcf_pkg::REG_SMOOTH, 32'h9);
		rchk(gcf_pkg::REG_SMOOTH, 32'h4, "smooth_max");
		$display("test cam done");

		wr(gcf_pkg::REG_PHASE, 32'h0);
		wr(gcf_pkg::REG_VANGLE, 32'h1575_29ff);
		wr(gcf_pkg::REG_VRATE, 32'h3e8);
		cyc(28);
		rd(gcf_pkg::REG_VANGLE);
		chk("vang_up", 32'h1, 32'(v < 32'ha));
		wr(gcf_pkg::REG_VRATE, 32'hffff_fc18);
		wr(gcf_pkg::REG_VANGLE, 32'h0);
		cyc(28);
		rd(gcf_pkg::REG_VANGLE);
		chk("vang_dn", 32'h1, 32'(v > 32'h1575_29f6 && v < 32'h1575_2a00));
		wr(gcf_pkg::REG_CTRL, 32'h4);
		rd(gcf_pkg::REG_VANGLE);
		cyc(40);
		rchk(gcf_pkg::REG_VANGLE, v, "vang_frozen");
		$display("test virtual done");
		print_verdict();
	end
endmodule : gcf_top_test
